// ### core/pcd_map.svh
`ifndef PCD_MAP_SVH
`define PCD_MAP_SVH

`define PCD_NUM_CH          4
`define PCD_CLK_PERIOD_NS   100
`define PCD_OEN_ON_US       200
`define PCD_OEN_ON_CYC      ((`PCD_OEN_ON_US * 1000) / `PCD_CLK_PERIOD_NS)
`define PCD_OEN_OFF_NS      20
`define PCD_OEN_OFF_CYC     1
`define PCD_PWS_CHG_NS      220
`define PCD_PWS_CHG_CYC     \
  ((`PCD_PWS_CHG_NS + `PCD_CLK_PERIOD_NS - 1) / `PCD_CLK_PERIOD_NS)
`define PCD_CODE_RX         3'h3
`define PCD_RDY_CNT_W       11
`define PCD_MC_CNT_W        3

`endif

// ### core/pcd_pkg.sv
package pcd_pkg;

  typedef enum logic [2:0] {
    PCD_LVL_HIZ,
    PCD_LVL_ZERO,
    PCD_LVL_PPOS,
    PCD_LVL_PNEG,
    PCD_LVL_SPOS,
    PCD_LVL_SNEG
  } pcd_level_t;

  typedef enum logic [1:0] {
    PCD_MODE_OFF,
    PCD_MODE_PULSE,
    PCD_MODE_CW0,
    PCD_MODE_CW1
  } pcd_mode_t;

  typedef enum logic [1:0] {
    PCD_RDY_OFF,
    PCD_RDY_WAIT,
    PCD_RDY_ON
  } pcd_rdy_state_t;

endpackage : pcd_pkg

// ### core/pcd_channel.sv
`timescale 1ns/1ns
`include "pcd_map.svh"

module pcd_channel
  import pcd_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  // Global controls
  input  wire logic       i_retime,
  input  wire logic       i_rtclk_rise,
  input  wire logic       i_active,
  input  wire pcd_mode_t  i_mode,
  // Channel code: rail select, low side, high side
  input  wire logic [2:0] i_code,
  // Decoded outputs
  output pcd_level_t      o_level,
  output logic            o_rx_state,
  output logic            o_tx_rx_switch,
  output logic            o_bleed_switch,
  output logic            o_receive_damper,
  output logic            o_external_wave_switch
);

  logic [2:0] held_code;
  logic [2:0] code;
  pcd_level_t next_level;
  logic       rx;

  // Captured code stays put between clock rises
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      held_code <= 3'h0;
    else if (i_ce && i_rtclk_rise)
      held_code <= i_code;
  end

  // Cw mode 1 ignores the retiming clock
  assign code = (i_retime && i_mode != PCD_MODE_CW1) ? held_code : i_code;
  assign rx   = i_active && code == `PCD_CODE_RX;

  always_comb
  begin
    next_level = PCD_LVL_HIZ;
    if (!i_active || i_mode == PCD_MODE_CW1)
      next_level = rx ? PCD_LVL_ZERO : PCD_LVL_HIZ;
    else
    begin
      case (code)
        3'h0:    next_level = PCD_LVL_ZERO;
        3'h1:    next_level = PCD_LVL_PPOS;
        3'h2:    next_level = PCD_LVL_PNEG;
        3'h3:    next_level = PCD_LVL_ZERO;
        3'h4:    next_level = PCD_LVL_ZERO;
        3'h5:    next_level = PCD_LVL_SPOS;
        3'h6:    next_level = PCD_LVL_SNEG;
        default: next_level = PCD_LVL_HIZ;
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_level                <= PCD_LVL_HIZ;
      o_rx_state             <= 1'b0;
      o_tx_rx_switch         <= 1'b0;
      o_bleed_switch         <= 1'b0;
      o_receive_damper       <= 1'b1;
      o_external_wave_switch <= 1'b0;
    end
    else if (i_ce)
    begin
      o_level                <= next_level;
      o_rx_state             <= rx;
      o_tx_rx_switch         <= rx;
      o_bleed_switch         <= rx;
      o_receive_damper       <= !rx;
      o_external_wave_switch <= i_active && i_mode == PCD_MODE_CW1
                                && !rx;
    end
  end

endmodule : pcd_channel

// ### core/pcd_top.sv
`timescale 1ns/1ns
`include "pcd_map.svh"

module pcd_top
  import pcd_pkg::*;
#(
  parameter int OEN_ON_CYC = `PCD_OEN_ON_CYC
)
(
  // Clock, reset, enable
  input  wire logic            i_mclk,
  input  wire logic            i_rst_n,
  input  wire logic            i_ce,
  // Global controls
  input  wire logic            i_reg_enable,
  input  wire logic            i_tx_output_enable,
  input  wire logic            i_secondary_strength_scale,
  input  wire logic            i_cw_mode_sel,
  input  wire logic            i_retime_clk,
  input  wire logic            i_overtemp,
  // Channel lines
  input  wire logic [3:0]      i_rail_sel,
  input  wire logic [3:0]      i_low_side_drive,
  input  wire logic [3:0]      i_high_side_drive,
  // Per channel outputs
  output pcd_level_t           o_level [4],
  output logic [3:0]           o_receive_state,
  output logic [3:0]           o_tx_rx_switch,
  output logic [3:0]           o_bleed_switch,
  output logic [3:0]           o_receive_damper,
  output logic [3:0]           o_external_wave_switch,
  // Status
  output pcd_mode_t            o_mode,
  output logic                 o_regulators_on,
  output logic                 o_tx_ready,
  output logic                 o_secondary_reduced,
  output logic                 o_strength_settled,
  output logic                 o_overtemp_n,
  output logic                 o_retime_active
);

  logic                     rtclk_q;
  logic                     retime;
  logic                     rtclk_rise;
  logic                     active;
  pcd_rdy_state_t           rdy_state;
  logic [`PCD_RDY_CNT_W+1:0] rdy_cnt;
  logic [`PCD_MC_CNT_W-1:0] mc_cnt;
  pcd_mode_t                mode;

  // Overtemperature and regulator state gate the mode and all channel outputs
  assign active = i_reg_enable && i_tx_output_enable && !i_overtemp
                  && rdy_state == PCD_RDY_ON;

  always_comb
  begin
    if (!active)
      mode = PCD_MODE_OFF;
    else if (i_cw_mode_sel)
      mode = PCD_MODE_CW1;
    else if (i_secondary_strength_scale)
      mode = PCD_MODE_PULSE;
    else
      mode = PCD_MODE_CW0;
  end

  // Retiming clock sampled as a plain input
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      rtclk_q <= 1'b0;
    else if (i_ce)
      rtclk_q <= i_retime_clk;
  end
  assign rtclk_rise = i_retime_clk && !rtclk_q;

  // Retiming latches once clock seen; drops when clock and all drives low
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      retime <= 1'b0;
    else if (i_ce)
    begin
      if (rtclk_rise)
        retime <= 1'b1;
      else if (!i_retime_clk && !rtclk_q
               && (i_low_side_drive | i_high_side_drive) == 4'h0)
        retime <= 1'b0;
    end
  end

  // Enable-on settle timer; off path is immediate
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      rdy_state <= PCD_RDY_OFF;
      rdy_cnt   <= '0;
    end
    else if (i_ce)
    begin
      case (rdy_state)
        PCD_RDY_OFF:
        begin
          rdy_cnt <= '0;
          if (i_reg_enable && i_tx_output_enable)
            rdy_state <= PCD_RDY_WAIT;
        end
        PCD_RDY_WAIT:
        begin
          if (!i_reg_enable || !i_tx_output_enable)
            rdy_state <= PCD_RDY_OFF;
          else if (rdy_cnt >= (`PCD_RDY_CNT_W+2)'(OEN_ON_CYC - 2))
            rdy_state <= PCD_RDY_ON;
          else
            rdy_cnt <= rdy_cnt + 1'b1;
        end
        PCD_RDY_ON:
        begin
          if (!i_reg_enable || !i_tx_output_enable)
            rdy_state <= PCD_RDY_OFF;
        end
        default: rdy_state <= PCD_RDY_OFF;
      endcase
    end
  end

  // Strength scale low-to-high settle
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      mc_cnt <= (`PCD_MC_CNT_W)'(`PCD_PWS_CHG_CYC); // Settle owed after reset
    else if (i_ce)
    begin
      if (!i_secondary_strength_scale)
        mc_cnt <= (`PCD_MC_CNT_W)'(`PCD_PWS_CHG_CYC);
      else if (mc_cnt != '0)
        mc_cnt <= mc_cnt - 1'b1;
    end
  end

  for (genvar ch = 0; ch < `PCD_NUM_CH; ch++)
  begin : g_ch
    pcd_channel u_ch (
      .i_mclk                 (i_mclk),
      .i_rst_n                (i_rst_n),
      .i_ce                   (i_ce),
      .i_retime               (retime),
      .i_rtclk_rise           (rtclk_rise),
      .i_active               (active),
      .i_mode                 (mode),
      .i_code                 ({i_rail_sel[ch], i_low_side_drive[ch],
                                i_high_side_drive[ch]}),
      .o_level                (o_level[ch]),
      .o_rx_state             (o_receive_state[ch]),
      .o_tx_rx_switch         (o_tx_rx_switch[ch]),
      .o_bleed_switch         (o_bleed_switch[ch]),
      .o_receive_damper       (o_receive_damper[ch]),
      .o_external_wave_switch (o_external_wave_switch[ch])
    );
  end

  // Mode and readiness status
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_mode     <= PCD_MODE_OFF;
      o_tx_ready <= 1'b0;
    end
    else if (i_ce)
    begin
      o_mode     <= mode;
      o_tx_ready <= rdy_state == PCD_RDY_ON;
    end
  end

  // Secondary rail strength status
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_secondary_reduced <= 1'b0;
      o_strength_settled  <= 1'b0;
    end
    else if (i_ce)
    begin
      o_secondary_reduced <= mode == PCD_MODE_CW0;
      o_strength_settled  <= i_secondary_strength_scale
                             && mc_cnt == '0;
    end
  end

  // Supply and thermal status
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_regulators_on <= 1'b0;
      o_overtemp_n    <= 1'b1;
    end
    else if (i_ce)
    begin
      o_regulators_on <= i_reg_enable;
      o_overtemp_n    <= !i_overtemp;
    end
  end

  // Retiming status
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      o_retime_active <= 1'b0;
    else if (i_ce)
      o_retime_active <= retime;
  end

endmodule : pcd_top

// ### verif/pcd_top_sva.sv
`timescale 1ns/1ns
module pcd_top_sva
  import pcd_pkg::*;
#(
  parameter int OEN_ON_CYC = 8
)
(
  // Clock, reset, controls
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic       i_reg_enable,
  input wire logic       i_tx_output_enable,
  input wire logic       i_secondary_strength_scale,
  input wire logic       i_cw_mode_sel,
  input wire logic       i_overtemp,
  // Watched outputs
  input wire pcd_level_t o_level [4],
  input wire logic [3:0] o_receive_state,
  input wire logic [3:0] o_tx_rx_switch,
  input wire logic [3:0] o_bleed_switch,
  input wire logic [3:0] o_receive_damper,
  input wire logic [3:0] o_external_wave_switch,
  input wire pcd_mode_t  o_mode,
  input wire logic       o_regulators_on,
  input wire logic       o_tx_ready,
  input wire logic       o_strength_settled,
  input wire logic       o_overtemp_n
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic      en;
  logic      secondary_strength_scale;
  logic      hiz;
  int        en_cnt;
  pcd_mode_t want;
  assign en  = i_reg_enable && i_tx_output_enable;
  assign secondary_strength_scale = i_secondary_strength_scale;
  assign hiz = o_level[0] == PCD_LVL_HIZ && o_level[1] == PCD_LVL_HIZ
            && o_level[2] == PCD_LVL_HIZ && o_level[3] == PCD_LVL_HIZ;
  // Run length of enable, so the settle wait can be bounded
  always_ff @(posedge i_mclk)
    en_cnt <= (en && i_rst_n) ? en_cnt + 1 : 0;
  always_ff @(posedge i_mclk)
    want <= i_cw_mode_sel ? PCD_MODE_CW1
          : (secondary_strength_scale ? PCD_MODE_PULSE : PCD_MODE_CW0);
  AST_OT_HIZ:
    assert property (i_overtemp |=>
                     hiz && !o_overtemp_n && &o_receive_damper)
    else $error("outputs active during overtemp");
  AST_OEN_OFF:
    assert property (!en |=> hiz && &o_receive_damper)
    else $error("outputs active after enable fall");
  AST_RX_LVL:
    assert property (o_receive_state[0] |->
                     o_level[0] == PCD_LVL_ZERO && !o_external_wave_switch[0])
    else $error("receive state without zero level");
  AST_REG_OFF:
    assert property (!i_reg_enable |=> o_mode == PCD_MODE_OFF
                     && !o_regulators_on ##1 hiz)
    else $error("device not disabled by regulator enable");
  AST_RX_SW:
    assert property (o_tx_rx_switch == o_receive_state
      && o_bleed_switch == o_receive_state
      && o_receive_damper == ~o_receive_state)
    else $error("switches disagree with receive state");
  AST_EXT_SW: assert property (o_external_wave_switch[0] |->
      o_level[0] == PCD_LVL_HIZ && o_receive_damper[0])
    else $error("external switch with driven output");
  AST_MODE:
    assert property (en && !i_overtemp |=>
                     o_mode == (o_tx_ready ? want : PCD_MODE_OFF))
    else $error("mode decode wrong");
  AST_READY: assert property ($rose(o_tx_ready) |-> en_cnt >= OEN_ON_CYC)
    else $error("ready too early");
  AST_STRENGTH:
    assert property (o_strength_settled |-> $past(secondary_strength_scale) && $past(secondary_strength_scale, 2)
                     && $past(secondary_strength_scale, 3))
    else $error("strength settled too early");
  cover property (o_mode == PCD_MODE_CW1 && |o_external_wave_switch);
  cover property (|o_receive_state);
  cover property ($rose(o_tx_ready));
  cover property (o_mode == PCD_MODE_CW0);
endmodule : pcd_top_sva

bind pcd_top pcd_top_sva #(.OEN_ON_CYC(OEN_ON_CYC)) u_pcd_top_sva (.*);

// ### verif/pcd_beamformer.sv
`timescale 1ns/1ns
module pcd_beamformer (
  // Clock, reset, requests
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_retime_en,
  input  wire logic [11:0] i_req,
  // Control pins
  output logic             o_retime_clk,
  output logic [3:0]       o_rail_sel,
  output logic [3:0]       o_low_side_drive,
  output logic [3:0]       o_high_side_drive
);
  logic [2:0] run;
  logic [1:0] gap;
  logic [3:0] rxing;
  logic       ok;

  function automatic logic tx(logic [2:0] code);
    return code[1:0] != 2'h0 && code != 3'h3;
  endfunction : tx

  assign rxing = ~o_rail_sel & o_low_side_drive & o_high_side_drive;
  // Drives wait for a running clock; clock winds down after them
  assign ok = i_retime_en ? run > 3'h1 : run == 3'h0;
  always_ff @(posedge i_mclk)
    if (!i_rst_n || (!i_retime_en && run == 3'h0))
    begin
      run          <= 3'h0;
      o_retime_clk <= 1'b0;
    end
    else
    begin
      run          <= i_retime_en ? run + {2'h0, run != 3'h7} : run - 3'h1;
      o_retime_clk <= ~o_retime_clk;
    end
  // Transmit only one cycle in four, and never straight after receive, keeps the duty low
  always_ff @(posedge i_mclk)
    gap <= i_rst_n ? gap + 2'h1 : 2'h0;
  always_ff @(posedge i_mclk)
    for (int c = 0; c < 4; c++)
      {o_rail_sel[c], o_low_side_drive[c], o_high_side_drive[c]} <=
        (!i_rst_n || !ok) ? 3'h0
        : (tx(i_req[3*c+:3]) && (|gap || rxing[c])) ? 3'h0
        : i_req[3*c+:3];
endmodule : pcd_beamformer

// ### verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import pcd_pkg::*;
  logic        clk, rst_n, ren, tx_output_enable, secondary_strength_scale, cw, ot, rt, rclk, rnd_on, chk;
  logic        red, otn, rta, r1, r2;
  logic [2:0]  code;
  logic [4:0]  got;
  logic [3:0]  sel, lo, hi, rx, ext;
  logic [11:0] req, p, h;
  logic [31:0] seed;
  pcd_level_t  lvl [4];
  int          n_errors, samples_checked;

  pcd_top #(.OEN_ON_CYC(8)) u_pcd_top (
    .i_mclk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_reg_enable(ren),
    .i_tx_output_enable(tx_output_enable), .i_secondary_strength_scale(secondary_strength_scale),
    .i_cw_mode_sel(cw), .i_retime_clk(rclk), .i_overtemp(ot),
    .i_rail_sel(sel), .i_low_side_drive(lo), .i_high_side_drive(hi),
    .o_level(lvl), .o_receive_state(rx), .o_tx_rx_switch(),
    .o_bleed_switch(), .o_receive_damper(), .o_external_wave_switch(ext),
    .o_mode(), .o_regulators_on(), .o_tx_ready(), .o_secondary_reduced(red),
    .o_strength_settled(), .o_overtemp_n(otn), .o_retime_active(rta));
  pcd_beamformer u_pcd_beamformer (
    .i_mclk(clk), .i_rst_n(rst_n), .i_retime_en(rt), .i_req(req),
    .o_retime_clk(rclk), .o_rail_sel(sel), .o_low_side_drive(lo),
    .o_high_side_drive(hi));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [4:0] dec(logic [2:0] c);
    if (!(ren && tx_output_enable && !ot)) return {PCD_LVL_HIZ, 2'b00};
    if (c == 3'h3) return {PCD_LVL_ZERO, 2'b10};
    if (cw) return {PCD_LVL_HIZ, 2'b01};
    case (c[1:0])
      2'b01: return {c[2] ? PCD_LVL_SPOS : PCD_LVL_PPOS, 2'b00};
      2'b10: return {c[2] ? PCD_LVL_SNEG : PCD_LVL_PNEG, 2'b00};
      2'b11: return {PCD_LVL_HIZ, 2'b00};
      default: return {PCD_LVL_ZERO, 2'b00};
    endcase
  endfunction : dec

  task automatic cmp(logic ok, string what);
    samples_checked++;
    if (!ok)
    begin
      n_errors++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : cmp

  task automatic summarize();
    $display("compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // cfg is {ren, oen, pws, cw, ot, rt}
  task automatic phase(logic [5:0] cfg, int n, string name);
    {ren, tx_output_enable, secondary_strength_scale, cw, ot, rt} <= cfg;
    chk = 1'b0;
    repeat (14) @(posedge clk);
    chk = 1'b1;
    repeat (n) @(posedge clk);
    $display("test %s done", name);
  endtask : phase

  always @(posedge clk)
    if (rnd_on)
      req <= 12'(xs());

  // Held code follows retime clock rises, as the device should
  always @(posedge clk)
  begin
    #1;
    for (int c = 0; c < 4; c++)
    begin
      code = (rt && !cw) ? h[3*c+:3] : p[3*c+:3];
      got  = {lvl[c], rx[c], ext[c]};
      if (chk) cmp(got === dec(code), "decode");
    end
    if (chk) cmp(otn === !ot, "overtemp flag");
    if (chk) cmp(red === (ren && tx_output_enable && !(ot || cw || secondary_strength_scale)), "reduced");
    if (chk) cmp(rta === rt, "retime flag");
    if (r1 && !r2)
      h = p;
    r2 = r1;
    r1 = rclk;
    for (int c = 0; c < 4; c++)
      p[3*c+:3] = {sel[c], lo[c], hi[c]};
  end

  initial
  begin
    {rst_n, ren, tx_output_enable, secondary_strength_scale, cw, ot, rt, chk, r1, r2} = '0;
    {req, p, h} = '0;
    seed = 32'h608b;
    rnd_on = 1'b1;
    n_errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    phase(6'b000000, 20, "regulators off");
    phase(6'b101000, 20, "output disabled");
    phase(6'b111000, 200, "pulse echo");
    // Each code held long enough to pass the duty limiter once
    rnd_on <= 1'b0;
    for (int k = 0; k < 8; k++)
      repeat (4) @(posedge clk) req <= {4{3'(k)}};
    rnd_on <= 1'b1;
    $display("test all codes done");
    phase(6'b110000, 150, "internal wave");
    phase(6'b110100, 150, "external wave");
    phase(6'b111001, 300, "retimed");
    phase(6'b111011, 20, "overtemp");
    phase(6'b101000, 20, "enable drop");
    summarize();
  end
endmodule : tb_top
